/* design/tph_params.svh */
`ifndef TPH_PARAMS_SVH
`define TPH_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define TPH_CLK_PERIOD_NS   20
`define TPH_LATCH_PULSE_NS  100
`define TPH_LATCH_CYC       ((`TPH_LATCH_PULSE_NS + `TPH_CLK_PERIOD_NS - 1) / `TPH_CLK_PERIOD_NS)
`define TPH_MOTOR_OS_NS     10000
`define TPH_MOTOR_OS_CYC    ((`TPH_MOTOR_OS_NS + `TPH_CLK_PERIOD_NS - 1) / `TPH_CLK_PERIOD_NS)
`define TPH_WD_TIMEOUT_NS   100000000
`define TPH_WD_CYC          (`TPH_WD_TIMEOUT_NS / `TPH_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Print line geometry, drive burn extra and strobe polarity switch bit
// ----------------------------------------------------------------
`define TPH_LINE_DOTS       320
`define TPH_GROUP_DOTS      64
`define TPH_GROUPS          5
`define TPH_LINE_WORDS      10
`define TPH_DRIVE_EXTRA     12'h040
`define TPH_VAR_HIGH_BIT    0

// ----------------------------------------------------------------
// Register byte offsets and burn base reset value
// ----------------------------------------------------------------
`define TPH_OFF_CTRL        12'h000
`define TPH_OFF_STATUS      12'h004
`define TPH_OFF_BURN_BASE   12'h008
`define TPH_OFF_HOST_LATCH  12'h00C
`define TPH_OFF_HOST_REGS   12'h010
`define TPH_OFF_IRQ_STAT    12'h014
`define TPH_OFF_IRQ_MASK    12'h018
`define TPH_OFF_LINE_BASE   12'h020
`define TPH_OFF_LINE_END    12'h044
`define TPH_BURN_BASE_RST   8'h40

`endif

/* design/tph_pkg.sv */
package tph_pkg;

    // Pins from outside the clock domain, synchronised as one bundle
    typedef struct packed {
        logic       paper_out;
        logic       head_up;
        logic       front_panel_reset;
        logic       host_write_strobe_n;
        logic       host_read_strobe_n;
        logic       host_reg_sel;
        logic [1:0] host_addr;
        logic [7:0] host_data;
        logic [7:0] supply_level;
        logic [7:0] head_temp;
        logic [3:0] config_switch;
    } tph_pins_t;

    typedef struct packed {
        logic [23:0] unused;
        logic        pending_flag_clear_n;
        logic        wd_kick;
        logic        clear_pending;
        logic        host_int_req;
        logic        beeper_gate_bit;
        logic        step_pulse;
        logic        motor_fire;
        logic        start_line;
    } tph_ctrl_t;

    typedef struct packed {
        logic [18:0] unused;
        logic        wd_seen;
        logic [3:0]  config_switch;
        logic        host_int;
        logic        zero_det;
        logic        feed_det;
        logic        motor_en;
        logic        head_up;
        logic        paper_out;
        logic        pending;
        logic        print_active;
    } tph_status_t;

    typedef struct packed {
        logic error;
        logic watchdog;
        logic line_done;
        logic host_data;
    } tph_irq_t;

    typedef enum logic [2:0] {
        TPH_IDLE, TPH_SHIFT_LO, TPH_SHIFT_HI, TPH_LATCH, TPH_BURN
    } tph_state_t;

endpackage : tph_pkg

/* design/tph_ctrl.sv */
// Function
// RQ1: shift 320 dots with inverted serial clock
// RQ2: pulse burn latch after all bits
// RQ3: burn five 64-dot groups in turn
// RQ4: burn time from supply, temperature, drive
// RQ5: motor steps four phases per pulse; code rotates one phase per step pulse
// RQ6: motor steps only while one-shot enabled
// RQ7: software senses print in progress
// RQ8: reset at power-up and on watchdog
// RQ9: front panel reset resets the controller
// RQ10: host loads latch and four nibble registers
// RQ11: host sees only the interrupt line
// RQ12: host write sets pending flag, grants access
// RQ13: pending flag exposes feed and zero detects
// RQ14: line memory only while flag cleared
// RQ15: program strobe direct, data select decoded
// RQ16: address captured by latch strobe, held
// RQ17: paper/head faults beep, gated, reported
// RQ18: switches select host strobe polarity
// RQ19: host access clears host interrupt
`include "tph_params.svh"
`timescale 1ns/10ps
`default_nettype none

module tph_ctrl #(
    parameter int WD_CYC = `TPH_WD_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire tph_pkg::tph_pins_t   pins,
    output logic                      head_data,
    output logic                      head_shift_clock,
    output logic                      burn_latch_bit,
    output logic [4:0]                burn_enable,
    output logic [3:0]                motor_phase,
    output logic                      motor_output_enable_n,
    output logic                      beeper,
    output logic                      host_int,
    output logic                      irq
);
    import tph_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    tph_pins_t  s1_q, s2_q, s3_q, pf_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pf_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pf_q <= (s2_q & s3_q) | (pf_q & (s2_q | s3_q));
        end
    end

    // ------------------------------------------------------------
    // Host side strobes
    // ------------------------------------------------------------
    logic high_pol, wr_act, rd_act, wr_prev_q, rd_prev_q, host_wr_edge, host_acc_edge;
    // RQ18 variant strobe polarity
    assign high_pol      = pf_q.config_switch[`TPH_VAR_HIGH_BIT];
    assign wr_act        = high_pol ? pf_q.host_write_strobe_n : ~pf_q.host_write_strobe_n;
    assign rd_act        = high_pol ? pf_q.host_read_strobe_n : ~pf_q.host_read_strobe_n;
    assign host_wr_edge  = wr_act & ~wr_prev_q;
    assign host_acc_edge = host_wr_edge | (rd_act & ~rd_prev_q);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [11:0] addr_q;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic        addr_strobe, access, wr_fire;
    logic        sel_ctrl, sel_status, sel_base, sel_latch, sel_regs, sel_istat, sel_imask;
    logic        sel_line, mapped, program_store_enable_n, data_mem_select_n;
    logic [3:0]  line_idx;
    tph_ctrl_t   ctrl_w;
    logic        pend_q, wd_fire_q, mot_en_n_q;
    tph_state_t  state_q;

    // RQ16 address latch strobe
    assign addr_strobe = psel & ~penable;
    assign access      = psel & penable & ~pready_q;
    assign wr_fire     = psel & penable & pready_q & pwrite;
    assign ctrl_w      = tph_ctrl_t'(pwdata);
    assign line_idx    = 4'((addr_q - `TPH_OFF_LINE_BASE) >> 2);
    assign sel_ctrl    = addr_q == `TPH_OFF_CTRL;
    assign sel_status  = addr_q == `TPH_OFF_STATUS;
    assign sel_base    = addr_q == `TPH_OFF_BURN_BASE;
    assign sel_latch   = addr_q == `TPH_OFF_HOST_LATCH;
    assign sel_regs    = addr_q == `TPH_OFF_HOST_REGS;
    assign sel_istat   = addr_q == `TPH_OFF_IRQ_STAT;
    assign sel_imask   = addr_q == `TPH_OFF_IRQ_MASK;
    assign sel_line    = (addr_q >= `TPH_OFF_LINE_BASE) && (addr_q <= `TPH_OFF_LINE_END)
                         && (addr_q[1:0] == 2'h0);
    // RQ15 program strobe direct, data select decoded
    assign program_store_enable_n = ~(psel & ~pwrite & sel_line);
    assign data_mem_select_n      = ~(psel & sel_line & program_store_enable_n & pwrite
                                      & ~pend_q) & program_store_enable_n;
    assign mapped = sel_ctrl | sel_status | sel_base | sel_latch | sel_regs | sel_istat
                    | sel_imask | (sel_line & ~(data_mem_select_n & program_store_enable_n));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_q <= 12'h000;
        end else if (addr_strobe) begin
            addr_q <= paddr;
        end
    end

    // ------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------
    logic [31:0] line_mem [`TPH_LINE_WORDS];
    logic [7:0]  burn_base_q, host_latch_q;
    logic [3:0]  host_regs_q [4];
    logic        beep_gate_q, host_int_q, feed_det_q, zero_det_q, wd_seen_q;
    tph_irq_t    istat_q, imask_q, ev;
    tph_status_t st;
    logic        clr_pend, err_now, err_prev_q;

    assign clr_pend = wr_fire & sel_ctrl & (ctrl_w.clear_pending | ~ctrl_w.pending_flag_clear_n);
    assign err_now  = pf_q.paper_out | pf_q.head_up;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burn_base_q <= `TPH_BURN_BASE_RST;
            beep_gate_q <= 1'b0;
            imask_q     <= '0;
        end else if (wr_fire) begin
            if (sel_base) burn_base_q <= pwdata[7:0];
            if (sel_ctrl) beep_gate_q <= ctrl_w.beeper_gate_bit;
            if (sel_imask) imask_q <= tph_irq_t'(pwdata[3:0]);
        end
    end

    // RQ14 line memory only while flag clear
    always_ff @(posedge clock) begin
        if (wr_fire && sel_line && !pend_q) begin
            line_mem[line_idx] <= pwdata;
        end
    end

    // RQ10 host latch and register file
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            host_latch_q <= 8'h00;
            host_regs_q  <= '{default: 4'h0};
        end else if (host_wr_edge) begin
            if (pf_q.host_reg_sel) host_regs_q[pf_q.host_addr] <= pf_q.host_data[3:0];
            else host_latch_q <= pf_q.host_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // Seen as active until idle, so no false edge after reset
            wr_prev_q  <= 1'b1;
            rd_prev_q  <= 1'b1;
            err_prev_q <= 1'b0;
            pend_q     <= 1'b0;
            host_int_q <= 1'b0;
            istat_q    <= '0;
            wd_seen_q  <= 1'b0;
        end else begin
            wr_prev_q  <= wr_act;
            rd_prev_q  <= rd_act;
            err_prev_q <= err_now;
            // RQ12 host write sets pending flag
            pend_q     <= host_wr_edge | (pend_q & ~clr_pend);
            // RQ19 host access clears interrupt
            host_int_q <= (wr_fire & sel_ctrl & ctrl_w.host_int_req)
                          | (host_int_q & ~host_acc_edge);
            istat_q    <= ev | (istat_q & ~((wr_fire & sel_istat) ? tph_irq_t'(pwdata[3:0]) : '0));
            wd_seen_q  <= wd_fire_q | (wd_seen_q & ~(wr_fire & sel_istat));
        end
    end

    // RQ13 detects visible through pending flag
    assign st.unused        = '0;
    assign st.wd_seen       = wd_seen_q;
    assign st.config_switch = pf_q.config_switch;
    assign st.host_int      = host_int_q;
    assign st.zero_det      = zero_det_q & pend_q;
    assign st.feed_det      = feed_det_q & pend_q;
    assign st.motor_en      = ~mot_en_n_q;
    assign st.head_up       = pf_q.head_up;
    assign st.paper_out     = pf_q.paper_out;
    assign st.pending       = pend_q;
    // RQ7 print in progress sensed
    assign st.print_active  = state_q != TPH_IDLE;

    logic [31:0] rd_mux;
    assign rd_mux = sel_ctrl   ? {24'h000000, 4'h0, host_int_q, beep_gate_q, 2'h0} :
                    sel_status ? 32'(st) :
                    sel_base   ? {24'h000000, burn_base_q} :
                    sel_latch  ? (pend_q ? {24'h000000, host_latch_q} : 32'h00000000) :
                    sel_regs   ? (pend_q ? {16'h0000, host_regs_q[3], host_regs_q[2],
                                            host_regs_q[1], host_regs_q[0]} : 32'h00000000) :
                    sel_istat  ? {28'h0000000, istat_q} :
                    sel_imask  ? {28'h0000000, imask_q} :
                    (sel_line & ~program_store_enable_n) ? line_mem[line_idx] : 32'h00000000;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
            irq       <= 1'b0;
        end else begin
            pready_q  <= access;
            prdata_q  <= (access & ~pwrite & mapped) ? rd_mux : 32'h00000000;
            pslverr_q <= access & ~mapped;
            irq       <= |(istat_q & imask_q);
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Supervisor
    // ------------------------------------------------------------
    logic [31:0] wd_cnt_q;
    logic        core_rst;
    // RQ8 watchdog on address strobe
    always_ff @(posedge clock) begin
        if (!rst_n || addr_strobe) begin
            wd_cnt_q  <= 32'h00000000;
            wd_fire_q <= 1'b0;
        end else begin
            wd_fire_q <= wd_cnt_q == 32'(WD_CYC - 1);
            wd_cnt_q  <= (wd_cnt_q == 32'(WD_CYC - 1)) ? 32'h00000000 : wd_cnt_q + 32'h1;
        end
    end
    // RQ9 front panel reset
    assign core_rst = !rst_n | wd_fire_q | pf_q.front_panel_reset;

    // ------------------------------------------------------------
    // Print engine
    // ------------------------------------------------------------
    logic [8:0]  bit_q;
    logic [2:0]  grp_q;
    logic [11:0] tmr_q;
    logic        hd_q, hclk_q, latch_q, start;
    logic [4:0]  ben_q;

    function automatic logic [11:0] tph_burn_len(input logic [7:0] base, input logic [7:0] volt,
                                                 input logic [7:0] temp, input logic drive);
        logic [11:0] n;
        n = {2'h0, base, 2'h0} + {4'h0, 8'hFF - volt} + {4'h0, 8'hFF - temp}
            + (drive ? `TPH_DRIVE_EXTRA : 12'h000);
        return (n == 12'h000) ? 12'h001 : n;
    endfunction : tph_burn_len

    assign start = wr_fire & sel_ctrl & ctrl_w.start_line;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            state_q <= TPH_IDLE;
            bit_q   <= 9'h000;
            grp_q   <= 3'h0;
            tmr_q   <= 12'h000;
            hd_q    <= 1'b0;
            hclk_q  <= 1'b0;
            latch_q <= 1'b0;
            ben_q   <= 5'h00;
        end else begin
            case (state_q)
                TPH_IDLE: begin
                    if (start) begin
                        state_q <= TPH_SHIFT_LO;
                        bit_q   <= 9'h000;
                    end
                end
                // RQ1 data then rising head clock
                TPH_SHIFT_LO: begin
                    hd_q    <= line_mem[bit_q[8:5]][bit_q[4:0]];
                    hclk_q  <= 1'b0;
                    state_q <= TPH_SHIFT_HI;
                end
                TPH_SHIFT_HI: begin
                    hclk_q <= 1'b1;
                    bit_q  <= bit_q + 9'h001;
                    if (bit_q == 9'(`TPH_LINE_DOTS - 1)) begin
                        // RQ2 latch after last bit
                        state_q <= TPH_LATCH;
                        tmr_q   <= 12'(`TPH_LATCH_CYC);
                    end else begin
                        state_q <= TPH_SHIFT_LO;
                    end
                end
                TPH_LATCH: begin
                    hclk_q  <= 1'b0;
                    latch_q <= tmr_q != 12'h000;
                    tmr_q   <= tmr_q - 12'h001;
                    if (tmr_q == 12'h000) begin
                        state_q <= TPH_BURN;
                        grp_q   <= 3'h0;
                        // RQ4 burn length from sensors
                        tmr_q   <= tph_burn_len(burn_base_q, pf_q.supply_level,
                                                pf_q.head_temp, ~mot_en_n_q);
                    end
                end
                // RQ3 one 64-dot group per enable
                TPH_BURN: begin
                    ben_q <= 5'h01 << grp_q;
                    tmr_q <= tmr_q - 12'h001;
                    if (tmr_q == 12'h001) begin
                        ben_q <= 5'h00;
                        grp_q <= grp_q + 3'h1;
                        tmr_q <= tph_burn_len(burn_base_q, pf_q.supply_level,
                                              pf_q.head_temp, ~mot_en_n_q);
                        if (grp_q == 3'(`TPH_GROUPS - 1)) state_q <= TPH_IDLE;
                    end
                end
                default: state_q <= TPH_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Paper feed motor
    // ------------------------------------------------------------
    logic [15:0] os_q;
    logic [3:0]  ph_q;
    logic        step_ok;
    // RQ6 steps only while enabled
    assign step_ok = wr_fire & sel_ctrl & ctrl_w.step_pulse & ~mot_en_n_q;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            os_q       <= 16'h0000;
            mot_en_n_q <= 1'b1;
            ph_q       <= 4'h1;
        end else begin
            if (wr_fire && sel_ctrl && ctrl_w.motor_fire) os_q <= 16'(`TPH_MOTOR_OS_CYC);
            else if (os_q != 16'h0000) os_q <= os_q - 16'h0001;
            mot_en_n_q <= ~((wr_fire & sel_ctrl & ctrl_w.motor_fire) | (os_q > 16'h0001));
            // RQ5 four-phase rotation
            if (step_ok) ph_q <= {ph_q[2:0], ph_q[3]};
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            feed_det_q <= 1'b0;
            zero_det_q <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            feed_det_q <= step_ok | (feed_det_q & ~clr_pend);
            zero_det_q <= ev.line_done | (zero_det_q & ~clr_pend);
        end
    end

    // ------------------------------------------------------------
    // Events and outputs
    // ------------------------------------------------------------
    assign ev.host_data = host_wr_edge;
    assign ev.line_done = (state_q == TPH_BURN) && (tmr_q == 12'h001)
                          && (grp_q == 3'(`TPH_GROUPS - 1));
    assign ev.watchdog  = wd_fire_q;
    assign ev.error     = err_now & ~err_prev_q;

    logic beep_q;
    always_ff @(posedge clock) begin
        if (!rst_n) beep_q <= 1'b0;
        // RQ17 gated fault beeper
        else beep_q <= err_now & beep_gate_q;
    end

    assign head_data             = hd_q;
    assign head_shift_clock      = hclk_q;
    assign burn_latch_bit        = latch_q;
    assign burn_enable           = ben_q;
    assign motor_phase           = ph_q;
    assign motor_output_enable_n = mot_en_n_q;
    assign beeper                = beep_q;
    // RQ11 interrupt is the only host output
    assign host_int              = host_int_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (core_rst);

    property p_latch_after_shift;
        (state_q == TPH_SHIFT_HI && bit_q == 9'(`TPH_LINE_DOTS - 1)) |=> ##1 latch_q;
    endproperty
    a_latch_after_shift: assert property (p_latch_after_shift) else $error("no latch"); // RQ2
    property p_latch_only_after;
        latch_q |-> state_q == TPH_LATCH && bit_q == 9'(`TPH_LINE_DOTS);
    endproperty
    a_latch_only_after: assert property (p_latch_only_after) else $error("early latch"); // RQ2
    property p_one_group;
        ben_q != 5'h00 |-> $onehot(ben_q) && state_q == TPH_BURN;
    endproperty
    a_one_group: assert property (p_one_group) else $error("bad burn group"); // RQ3
    property p_clk_edge;
        $rose(hclk_q) |-> $past(state_q) == TPH_SHIFT_HI;
    endproperty
    a_clk_edge: assert property (p_clk_edge) else $error("stray head clock"); // RQ1
    property p_step_gate;
        ((ph_q != $past(ph_q)) && !$past(core_rst)) |-> !$past(mot_en_n_q);
    endproperty
    a_step_gate: assert property (p_step_gate) else $error("step while disabled"); // RQ6
    property p_step_rot;
        step_ok |=> ph_q == {$past(ph_q[2:0]), $past(ph_q[3])};
    endproperty
    a_step_rot: assert property (p_step_rot) else $error("bad phase"); // RQ5
    property p_pend_set;
        host_wr_edge |=> pend_q ##1 istat_q.host_data;
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("pending not set"); // RQ12
    property p_int_clear;
        (host_acc_edge && !(wr_fire && sel_ctrl && ctrl_w.host_int_req)) |=> !host_int_q;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("host int kept"); // RQ19
    property p_beep;
        (err_now && beep_gate_q) |=> beep_q;
    endproperty
    a_beep: assert property (p_beep) else $error("no beep"); // RQ17
    property p_mem_lock;
        (wr_fire && sel_line && pend_q) |=> pslverr_q == 1'b0 && line_mem[$past(line_idx)] ===
            $past(line_mem[line_idx]);
    endproperty
    a_mem_lock: assert property (p_mem_lock) else $error("memory written while pending"); // RQ14

    c_line:  cover property (ev.line_done);
    c_step:  cover property (step_ok ##[1:20] step_ok);
    c_host:  cover property (host_wr_edge ##[1:50] clr_pend);
    c_beep:  cover property ($rose(beep_q));

endmodule : tph_ctrl

`default_nettype wire

/* testbench/tph_far_end.sv */
`timescale 1ns/10ps
`default_nettype none
// ------
// Host bus and print mechanism model
// ------
module tph_far_end (
    input  wire logic          clock,
    input  wire logic          head_data,
    input  wire logic          head_shift_clock,
    input  wire logic          burn_latch_bit,
    input  wire logic [4:0]    burn_enable,
    output tph_pkg::tph_pins_t pins
);
    import tph_pkg::*;
    logic [319:0] line;
    int           bits;
    int           lat_bits;
    logic [4:0]   groups;
    initial begin
        pins = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 8'h00, 8'hFF, 8'hFF, 4'hA};
        bits = 0;
        lat_bits = 0;
        groups = 5'h00;
    end
    always @(posedge head_shift_clock) begin
        line <= {head_data, line[319:1]};
        bits <= bits + 1;
    end
    always @(posedge burn_latch_bit) begin
        lat_bits <= bits;
        bits <= 0;
    end
    always @(posedge clock) begin
        groups <= burn_latch_bit ? 5'h00 : groups | burn_enable;
    end
    task automatic hwr(input logic [7:0] d);
        @(posedge clock);
        pins.host_data <= d;
        repeat (4) @(posedge clock);
        pins.host_write_strobe_n <= 1'b0;
        repeat (6) @(posedge clock);
        pins.host_write_strobe_n <= 1'b1;
        repeat (4) @(posedge clock);
        pins.host_data <= ~d;
    endtask : hwr
endmodule : tph_far_end
`default_nettype wire

/* testbench/thermal_print_head_controller_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module thermal_print_head_controller_bench;
    import tph_pkg::*;
    logic         clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic         hd, hc, bl, mo_n, beeper, host_int, irq;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [319:0] ln;
    logic [4:0]   be;
    logic [3:0]   ph;
    tph_pins_t    pins;
    int           bad_count, compares;
    tph_ctrl #(.WD_CYC(2000)) DUT (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .pins, .head_data(hd), .head_shift_clock(hc),
        .burn_latch_bit(bl), .burn_enable(be), .motor_phase(ph),
        .motor_output_enable_n(mo_n), .beeper, .host_int, .irq);
    tph_far_end far (.clock, .head_data(hd), .head_shift_clock(hc),
        .burn_latch_bit(bl), .burn_enable(be), .pins);
    task automatic summarize;
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            summarize();
        end
    endtask : apb
    task automatic s_host;
        apb(1'b1, 12'h018, 32'h00000001);
        apb(1'b1, 12'h000, 32'h00000010);
        repeat (2) @(posedge clock);
        chk("host_int", 1, host_int);
        far.hwr(8'hA5);
        repeat (2) @(posedge clock);
        chk("host_int_clr", 0, host_int);
        chk("irq", 1, irq);
        apb(1'b0, 12'h004, 32'h00000000);
        chk("pending", 1, rd[1]);
        apb(1'b0, 12'h00C, 32'h00000000);
        chk("latch", 32'h000000A5, rd);
        apb(1'b1, 12'h020, 32'h00000001);
        chk("line_err", 1, er);
        apb(1'b1, 12'h014, 32'h00000001);
        repeat (2) @(posedge clock);
        chk("irq_clr", 0, irq);
        apb(1'b1, 12'h000, 32'h00000020);
    endtask : s_host
    task automatic s_print;
        int n;
        for (int i = 0; i < 10; i++) begin
            ln[i*32 +: 32] = 32'h9E3779B9 * (i + 1);
            apb(1'b1, 12'h020 + 12'(4 * i), ln[i*32 +: 32]);
        end
        apb(1'b1, 12'h000, 32'h00000001);
        apb(1'b0, 12'h004, 32'h00000000);
        chk("busy", 1, rd[0]);
        n = 0;
        while (rd[0] !== 1'b0 && n < 1000) begin
            apb(1'b0, 12'h004, 32'h00000000);
            n++;
        end
        chk("idle", 0, rd[0]);
        if (n == 1000) summarize();
        chk("bits", 320, far.lat_bits);
        for (int i = 0; i < 10; i++) chk("line", ln[i*32 +: 32], far.line[i*32 +: 32]);
        chk("groups", 32'h0000001F, far.groups);
    endtask : s_print
    task automatic s_motor;
        apb(1'b1, 12'h000, 32'h00000004);
        repeat (3) @(posedge clock);
        chk("phase", 32'h1, ph);
        apb(1'b1, 12'h000, 32'h00000002);
        apb(1'b1, 12'h000, 32'h00000004);
        repeat (3) @(posedge clock);
        chk("phase", 32'h2, ph);
        chk("motor_en_n", 0, mo_n);
        far.hwr(8'h3C);
        apb(1'b0, 12'h004, 32'h00000000);
        chk("detects", 32'h1, rd[6:5]);
        far.pins.paper_out <= 1'b1;
        apb(1'b1, 12'h000, 32'h00000008);
        repeat (5) @(posedge clock);
        chk("beeper", 1, beeper);
    endtask : s_motor
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        bad_count = 0;
        compares = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, 12'h004, 32'h00000000);
        chk("status", 32'h00000A00, rd);
        apb(1'b0, 12'h008, 32'h00000000);
        chk("burn_base", 32'h00000040, rd);
        apb(1'b1, 12'h01C, 32'h000000FF);
        chk("unmapped", 1, er);
        s_host();
        s_print();
        s_motor();
        summarize();
    end
endmodule : thermal_print_head_controller_bench
`default_nettype wire
